/* hw/sram_host.sv */
`timescale 1ns/1ps
// Functional notes
// - host spaces cycles at least 70 or 85 ns apart
// - host holds write strobe low at least 55 or 65 ns
// - host sets write data 30 or 35 ns before strobe rise, holds after
// - host sets address 65 or 75 ns before strobe rise, before it falls
// - after write-strobe-ended write, address held 15 ns, data 10 ns
module sram_host
  import sram_host_pkg::*;
#(
  parameter speed_grade_type GRADE = GRADE_FAST,
  parameter int LOCKOUT_CYC = LOCKOUT_CYC_DEF,
  parameter int RECOVERY_CYC = RECOVERY_CYC_DEF
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  input wire sram_req_type req_i,
  output logic req_ready_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic rdata_valid_o,
  input wire logic power_fail_i,
  output logic power_ok_o,
  output logic [ADDR_W-1:0] byte_addr_o,
  output strobe_type strobe_o,
  input wire logic [DATA_W-1:0] byte_bus_i,
  output logic [DATA_W-1:0] byte_bus_o,
  output logic byte_bus_oe_o
);
  // grade-dependent counts
  localparam int ACC_CYC = (GRADE == GRADE_FAST) ? ACC_FAST : ACC_SLOW;
  localparam int PULSE_CYC = (GRADE == GRADE_FAST) ? PULSE_FAST : PULSE_SLOW;
  localparam int GAP_CYC = (GRADE == GRADE_FAST) ? CYC_FAST : CYC_SLOW;
  localparam logic [CNT_W-1:0] ACC_N = CNT_W'(ACC_CYC);
  localparam logic [CNT_W-1:0] PULSE_N = CNT_W'(PULSE_CYC);
  localparam logic [CNT_W-1:0] GAP_N = CNT_W'(GAP_CYC);
  localparam logic [CNT_W-1:0] HOLD_N = CNT_W'(HOLD_CYC);
  localparam logic [CNT_W-1:0] FLOAT_N = CNT_W'(FLOAT_CYC);
  localparam logic [CNT_W-1:0] LOCK_N = CNT_W'(LOCKOUT_CYC);
  localparam logic [CNT_W-1:0] RECOV_N = CNT_W'(RECOVERY_CYC);

  host_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic write_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] bus_s1_q, bus_s2_q;
  logic pf_s1_q, pf_s2_q;
  logic pf_seen_q;
  logic [CNT_W-1:0] recov_q;
  logic protect;
  logic wr_now;
  logic [1:0] rd_pipe_q;

  // two-flop sync of pins from outside the clock domain
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      bus_s1_q <= 8'h00;
      bus_s2_q <= 8'h00;
      pf_s1_q <= 1'b1;
      pf_s2_q <= 1'b1;
    end else begin
      bus_s1_q <= byte_bus_i;
      bus_s2_q <= bus_s1_q;
      pf_s1_q <= power_fail_i;
      pf_s2_q <= pf_s1_q;
    end
  end

  // recovery timer: stays protected while supply low and for a while after
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      recov_q <= RECOV_N;
    end else if (pf_s2_q) begin
      recov_q <= RECOV_N;
    end else if (recov_q != '0) begin
      recov_q <= recov_q - 1'b1;
    end
  end

  // one lockout per fail event, taken only if the sequencer is idle on the cycle the synced fail rises
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pf_seen_q <= 1'b0;
    end else begin
      pf_seen_q <= pf_s2_q;
    end
  end

  assign protect = pf_s2_q || (recov_q != '0);
  assign power_ok_o = !protect;

  // sequencer: setup, strobe, hold, gap
  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (pf_s2_q && !pf_seen_q) begin
          state_d = ST_LOCK;
          cnt_d = LOCK_N;
        end else if (req_valid_i && !protect) begin
          state_d = ST_SETUP;
          cnt_d = '0;
        end
      end
      ST_SETUP: begin
        state_d = ST_STROBE;
        cnt_d = write_q ? PULSE_N : ACC_N;
      end
      ST_STROBE: begin
        if (cnt_q <= 24'h000001) begin
          state_d = ST_HOLD;
          cnt_d = write_q ? HOLD_N : FLOAT_N;
        end
      end
      ST_HOLD: begin
        if (cnt_q <= 24'h000001) begin
          state_d = ST_GAP;
          cnt_d = GAP_N;
        end
      end
      ST_GAP: begin
        if (cnt_q <= 24'h000001) begin
          state_d = ST_IDLE;
        end
      end
      ST_LOCK: begin
        if (cnt_q <= 24'h000001) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 24'h000000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // request capture, address held through whole cycle
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      write_q <= 1'b0;
      wdata_q <= 8'h00;
      byte_addr_o <= 19'h00000;
    end else if (state_q == ST_IDLE && state_d == ST_SETUP) begin
      write_q <= req_i.write;
      wdata_q <= req_i.wdata;
      byte_addr_o <= req_i.byte_addr;
    end
  end

  // direction of the cycle being set up; write_q is still stale on the take edge
  assign wr_now = (state_q == ST_IDLE) ? req_i.write : write_q;

  // strobes registered: select spans strobe phase, plus hold in writes, write strobe inside it
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      strobe_o <= '{sel_b: 1'b1, drive_b: 1'b1, wr_b: 1'b1};
      byte_bus_o <= 8'h00;
      byte_bus_oe_o <= 1'b0;
    end else begin
      // select in strobe phase and, in writes, hold too, so write ends on write strobe, not select
      strobe_o.sel_b <= !(state_d == ST_STROBE || (state_d == ST_HOLD && write_q));
      // drive kept high in writes, avoiding bus contention
      strobe_o.drive_b <= !(state_d == ST_STROBE && !write_q);
      strobe_o.wr_b <= !(state_d == ST_STROBE && write_q);
      // data driven from setup through hold, before and after strobe
      byte_bus_oe_o <= wr_now && (state_d == ST_SETUP || state_d == ST_STROBE || state_d == ST_HOLD);
      byte_bus_o <= req_valid_i && state_q == ST_IDLE ? req_i.wdata : wdata_q;
    end
  end

  // marks the edge where the first sync flop catches the driven byte, two edges deep
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rd_pipe_q <= 2'h0;
    end else begin
      rd_pipe_q <= {rd_pipe_q[0], (state_q == ST_STROBE && state_d == ST_HOLD && !write_q)};
    end
  end

  // read data taken once it has crossed both sync flops
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= 1'b0;
      if (rd_pipe_q[1]) begin
        rdata_o <= bus_s2_q;
        rdata_valid_o <= 1'b1;
      end
    end
  end

  assign req_ready_o = (state_q == ST_IDLE) && !protect && !(pf_s2_q && !pf_seen_q);

  // checks
  // write ends on the write strobe while select still holds
  sequence s_write_end;
    strobe_o.wr_b && !strobe_o.sel_b;
  endsequence

  a_write_pulse_len: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $fell(strobe_o.wr_b) |-> !strobe_o.sel_b ##1 s_write_end)
    else $error("write strobe too short");
  a_write_sel_overlap: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !strobe_o.wr_b |-> !strobe_o.sel_b && strobe_o.drive_b)
    else $error("write strobe outside select");
  a_data_before_rise: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(strobe_o.wr_b) |-> $past(byte_bus_oe_o) && byte_bus_oe_o)
    else $error("write data not held around strobe rise");
  a_addr_stable_sel: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !strobe_o.sel_b && !$past(strobe_o.sel_b) |-> $stable(byte_addr_o))
    else $error("address moved during select");
  a_no_access_protect: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    protect && state_q == ST_IDLE |=> strobe_o.sel_b)
    else $error("access started while protected");
  a_cycle_spacing: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(strobe_o.sel_b) |-> strobe_o.sel_b [*2])
    else $error("cycles too close");
  a_no_contention: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !strobe_o.drive_b |-> !byte_bus_oe_o)
    else $error("bus contention");
  a_read_result: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    rdata_valid_o |-> !write_q ##1 !rdata_valid_o)
    else $error("read result malformed");
endmodule : sram_host

/* include/sram_host_pkg.sv */
package sram_host_pkg;
  // speed grade selector
  typedef enum logic {
    GRADE_FAST = 1'b0,
    GRADE_SLOW = 1'b1
  } speed_grade_type;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 100;

  // timing figures in ns, fast and slow grade
  localparam int CYCLE_NS_FAST = 70;
  localparam int CYCLE_NS_SLOW = 85;
  localparam int ADDR_ACCESS_NS_FAST = 70;
  localparam int ADDR_ACCESS_NS_SLOW = 85;
  localparam int DRIVE_ACCESS_NS_FAST = 35;
  localparam int DRIVE_ACCESS_NS_SLOW = 45;
  localparam int WR_PULSE_NS_FAST = 55;
  localparam int WR_PULSE_NS_SLOW = 65;
  localparam int WR_DATA_SETUP_NS_FAST = 30;
  localparam int WR_DATA_SETUP_NS_SLOW = 35;
  localparam int ADDR_SETUP_NS_FAST = 65;
  localparam int ADDR_SETUP_NS_SLOW = 75;
  localparam int ADDR_HOLD_NS = 15;
  localparam int DATA_HOLD_NS = 10;
  localparam int FLOAT_NS = 35;

  // power-fail figures
  localparam int PROTECT_DELAY_US = 150;
  localparam int FAST_FALL_EXTRA_US = 200;
  localparam int RECOVERY_TIME_MS = 120;

  // least times round up to whole cycles, at least one
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles

  localparam int CYC_FAST = min_cycles(CYCLE_NS_FAST);
  localparam int CYC_SLOW = min_cycles(CYCLE_NS_SLOW);
  localparam int ACC_FAST = min_cycles(ADDR_ACCESS_NS_FAST);
  localparam int ACC_SLOW = min_cycles(ADDR_ACCESS_NS_SLOW);
  localparam int PULSE_FAST = min_cycles(WR_PULSE_NS_FAST);
  localparam int PULSE_SLOW = min_cycles(WR_PULSE_NS_SLOW);
  localparam int HOLD_CYC = min_cycles(ADDR_HOLD_NS);
  localparam int FLOAT_CYC = min_cycles(FLOAT_NS);
  // power-fail lockout: worst deselect plus fast-fall extra
  localparam int LOCKOUT_US = PROTECT_DELAY_US + FAST_FALL_EXTRA_US;
  localparam int LOCKOUT_CYC_DEF = LOCKOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC_DEF = RECOVERY_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // request from user logic
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] byte_addr;
    logic [DATA_W-1:0] wdata;
  } sram_req_type;

  // strobes toward the memory, active low
  typedef struct packed {
    logic sel_b;
    logic drive_b;
    logic wr_b;
  } strobe_type;

  // host sequencer states, gray from idle to gap; gap back to idle flips two bits
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b010,
    ST_GAP = 3'b110,
    ST_LOCK = 3'b100
  } host_state_type;
endpackage : sram_host_pkg

/* sim/sram_host_tb.sv */
`timescale 1ns/1ps
module sram_host_tb;
  import sram_host_pkg::*;
  localparam int RECOV_N = 20;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic req_valid_i = 1'b0;
  sram_req_type req_i = '0;
  logic power_fail_i = 1'b0;
  logic req_ready_o, rdata_valid_o, power_ok_o, byte_bus_oe_o;
  logic [DATA_W-1:0] rdata_o, byte_bus_o, bus_w;
  logic [ADDR_W-1:0] byte_addr_o;
  strobe_type strobe_o;
  int err_count = 0;
  int n_checks = 0;
  int seed = 69;
  logic [DATA_W-1:0] exp_q [$];
  logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] addrs [$];

  always #50 clock_i = ~clock_i;

  sram_host #(.GRADE(GRADE_FAST), .LOCKOUT_CYC(8), .RECOVERY_CYC(RECOV_N)) dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
    .power_fail_i(power_fail_i), .power_ok_o(power_ok_o), .byte_addr_o(byte_addr_o),
    .strobe_o(strobe_o), .byte_bus_i(bus_w), .byte_bus_o(byte_bus_o), .byte_bus_oe_o(byte_bus_oe_o));

  sram_mem_model mem (.power_fail_i(power_fail_i), .byte_addr_i(byte_addr_o), .strobe_i(strobe_o),
    .host_data_i(byte_bus_o), .host_oe_i(byte_bus_oe_o), .bus_o(bus_w));

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic summarize();
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // bounded wait for ready at falling edges, returns cycles spent
  task automatic wait_ready(output int n);
    n = 0;
    while (req_ready_o !== 1'b1 && n < 500) begin
      @(negedge clock_i);
      n++;
    end
    check(n < 500, 1'b1, "ready timeout");
  endtask : wait_ready

  // one request; reads note the expected byte for the monitor
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(negedge clock_i);
    wait_ready(n);
    req_i = '{write: wr, byte_addr: a, wdata: d};
    req_valid_i = 1'b1;
    if (wr) shadow[a] = d;
    else exp_q.push_back(shadow[a]);
    @(negedge clock_i);
    req_valid_i = 1'b0;
  endtask : access

  // monitor: results against notes, write cycles against bus duties
  always @(posedge clock_i) begin
    if (rst_b_i && rdata_valid_o === 1'b1) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0, "read data not asked for");
      else check(rdata_o, exp_q.pop_front(), "read data");
    end
    if (rst_b_i && strobe_o.wr_b === 1'b0) begin
      check(byte_bus_oe_o, 1'b1, "host drives data in write");
      check(strobe_o.drive_b, 1'b1, "output enable kept high in write");
      check(req_i.byte_addr === byte_addr_o, 1'b1, "write address");
    end
  end

  initial begin
    #2000000;
    err_count++;
    summarize();
  end

  initial begin
    int n;
    repeat (6) @(negedge clock_i);
    rst_b_i = 1'b1;
    check(strobe_o, 3'b111, "strobes after reset");
    check(byte_bus_oe_o, 1'b0, "bus released after reset");
    check(power_ok_o, 1'b0, "protected after reset");
    // both ends of the address range plus random places
    addrs = '{19'h00000, 19'h7FFFF};
    repeat (12) addrs.push_back(ADDR_W'($random(seed)));
    foreach (addrs[k]) access(1'b1, addrs[k], DATA_W'($random(seed)));
    foreach (addrs[k]) access(1'b0, addrs[k], 8'h00);
    repeat (10) @(negedge clock_i);
    // supply failure: host must refuse and stay off the bus
    power_fail_i = 1'b1;
    repeat (4) @(negedge clock_i);
    check(req_ready_o, 1'b0, "ready in power fail");
    check(power_ok_o, 1'b0, "power ok in power fail");
    req_i = '{write: 1'b1, byte_addr: addrs[0], wdata: 8'h3C};
    req_valid_i = 1'b1;
    repeat (60) @(negedge clock_i);
    req_valid_i = 1'b0;
    power_fail_i = 1'b0;
    wait_ready(n);
    check(n >= RECOV_N, 1'b1, "recovery time kept");
    // stored bytes survive, refused write left no trace
    foreach (addrs[k]) access(1'b0, addrs[k], 8'h00);
    repeat (12) @(negedge clock_i);
    check(exp_q.size(), 0, "reads still owed");
    summarize();
  end
endmodule : sram_host_tb

/* sim/sram_mem_model.sv */
`timescale 1ns/1ps
module sram_mem_model
  import sram_host_pkg::*;
#(
  parameter int PROTECT_NS = 4000,
  parameter int RECOVER_NS = 1000
) (
  input wire logic power_fail_i,
  input wire logic [ADDR_W-1:0] byte_addr_i,
  input wire strobe_type strobe_i,
  input wire logic [DATA_W-1:0] host_data_i,
  input wire logic host_oe_i,
  output logic [DATA_W-1:0] bus_o
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic prot = 1'b0;
  logic [DATA_W-1:0] last = 8'h00;
  logic wr_on;
  logic rd_on;
  logic [DATA_W-1:0] rd_val;
  logic wr_was = 1'b0;
  // write window: later fall to earlier rise; read needs strobe high
  assign wr_on = !prot && !strobe_i.sel_b && !strobe_i.wr_b;
  assign rd_on = !prot && !strobe_i.sel_b && strobe_i.wr_b && !strobe_i.drive_b;
  assign rd_val = mem.exists(byte_addr_i) ? mem[byte_addr_i] : 8'hA5;
  // released wire shows inverse of last level, no pull resistor
  assign bus_o = host_oe_i ? host_data_i : (rd_on ? rd_val : ~last);
  always @(bus_o) begin
    if (host_oe_i || rd_on) last = bus_o;
  end
  // store at end of window unless protection cut it short; unknown at start-up is no window
  always @(wr_on) begin
    if (wr_on === 1'b0 && wr_was && !prot) mem[byte_addr_i] = host_oe_i ? host_data_i : ~last;
    wr_was = (wr_on === 1'b1);
  end
  // deselect after a delay, released only after recovery
  always @(posedge power_fail_i) begin
    #(PROTECT_NS);
    if (power_fail_i) prot = 1'b1;
  end
  always @(negedge power_fail_i) begin
    #(RECOVER_NS);
    if (!power_fail_i) prot = 1'b0;
  end
endmodule : sram_mem_model
